// ==== resistive_touch_engine.sv ====
// resistive touch engine: acquisition sequencer and readout registers
`timescale 1ns/100ps
`default_nettype none

module resistive_touch_engine #(
   parameter int CONT_CYCLES = touch_pkg::CONT_CYCLES_DEF  // cont. spacing
) (
   input  wire logic                         clk,         // system clock
   input  wire logic                         rst,         // async, high
   input  wire logic [1:0]                   mode,        // acq mode field
   input  wire logic                         mode_wr,     // mode write pulse
   input  wire logic                         frame_sync,  // frame pulse
   input  wire logic                         pen_down,    // panel contact
   input  wire logic [15:0]                  pressure_threshold_reg, // thr
   input  wire logic [touch_pkg::COEF_W-1:0] coef_a,      // transform a
   input  wire logic [touch_pkg::COEF_W-1:0] coef_b,      // transform b
   input  wire logic [touch_pkg::COEF_W-1:0] coef_c,      // transform c
   input  wire logic [touch_pkg::COEF_W-1:0] coef_d,      // transform d
   input  wire logic [touch_pkg::COEF_W-1:0] coef_e,      // transform e
   input  wire logic [touch_pkg::COEF_W-1:0] coef_f,      // transform f
   input  wire logic                         adc_done,    // result pulse
   input  wire logic [touch_pkg::ADC_W-1:0]  adc_data,    // adc result
   input  wire logic                         tag_ack,     // lookup finished
   input  wire logic [7:0]                   tag_data,    // looked-up tag
   output logic                              adc_start,   // convert pulse
   output logic [1:0]                        mux_sel,     // adc input mux
   output logic                              sw_x_drive,  // x plate switch
   output logic                              sw_y_drive,  // y plate switch
   output logic                              sw_z_drive,  // z path switch
   output logic [31:0]                       raw_coord_reg,    // x hi, y lo
   output logic [31:0]                       screen_coord_reg, // x hi, y lo
   output logic [31:0]                       tag_lookup_coord_reg, // x, y
   output logic [15:0]                       contact_resistance_reg, // rz
   output logic [7:0]                        tag_reg,     // last tag
   output logic                              tag_req,     // lookup request
   output logic                              touch_event, // pen-down pulse
   output logic                              acq_done     // update pulse
);
   import touch_pkg::*;

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   localparam logic [15:0] CONT_LAST = 16'(CONT_CYCLES - 1);  // wrap

   typedef enum logic [4:0] {
      S_IDLE = 5'h01,  // waiting for a trigger
      S_XC   = 5'h02,  // converting x
      S_YC   = 5'h04,  // converting y
      S_ZC   = 5'h08,  // converting contact resistance
      S_XF   = 5'h10   // waiting for the transform
   } st_e;

   typedef struct packed {
      st_e              state;    // sequencer state
      logic [15:0]      cnt;      // continuous spacing counter
      logic             pend;     // trigger waiting for idle
      logic             pen;      // pen level, last cycle
      logic             pen_s;    // pen level at z conversion
      logic [ADC_W-1:0] x_s;      // captured x
      logic [ADC_W-1:0] y_s;      // captured y
      logic [ADC_W-1:0] z_s;      // captured resistance
      logic             xf_go;    // transform start
      logic             adc_start;
      logic [1:0]       mux_sel;
      logic             sw_x;
      logic             sw_y;
      logic             sw_z;
      logic [15:0]      raw_x;
      logic [15:0]      raw_y;
      logic [15:0]      scr_x;
      logic [15:0]      scr_y;
      logic [15:0]      tag_x;
      logic [15:0]      tag_y;
      logic [15:0]      rz;
      logic [7:0]       tag;
      logic             tag_req;
      logic             touched;  // last acquisition accepted
      logic             pen_evt;
      logic             acq_done;
   } eng_s;

   eng_s             q, d;       // state and next value
   logic             trig;       // acquisition trigger this cycle
   logic             accept;     // sample passes the threshold
   logic [CRD_W-1:0] xf_sx;      // transform output x
   logic [CRD_W-1:0] xf_sy;      // transform output y
   logic             xf_done;    // transform output valid

   // -------------------------------------------------------------------
   // transform
   // -------------------------------------------------------------------
   touch_xform u_xform (
      .clk    (clk),
      .rst    (rst),
      .go     (q.xf_go),
      .x      (q.x_s),
      .y      (q.y_s),
      .coef_a (coef_a),
      .coef_b (coef_b),
      .coef_c (coef_c),
      .coef_d (coef_d),
      .coef_e (coef_e),
      .coef_f (coef_f),
      .sx     (xf_sx),
      .sy     (xf_sy),
      .done   (xf_done)
   );

   // -------------------------------------------------------------------
   // next state
   // -------------------------------------------------------------------
   always_comb begin
      d           = q;
      d.adc_start = 1'b0;
      d.xf_go     = 1'b0;
      d.acq_done  = 1'b0;
      // pen detection runs in every mode, including off
      d.pen       = pen_down;
      d.pen_evt   = pen_down & ~q.pen;
      // trigger sources per mode
      trig = ((mode == MODE_ONESHOT) && mode_wr)
           | ((mode == MODE_FRAME) && frame_sync)
           | ((mode == MODE_CONT) && (q.cnt == CONT_LAST));
      // lower reading means firmer press; accept below threshold
      accept = q.pen_s && ({ZPAD, q.z_s} < pressure_threshold_reg);
      // spacing counter only runs in continuous mode
      if (mode == MODE_CONT) begin
         d.cnt = (q.cnt == CONT_LAST) ? 16'h0000 : q.cnt + 16'h0001;
      end else begin
         d.cnt = 16'h0000;
      end
      // off mode drops any waiting trigger
      if (mode == MODE_OFF) begin
         d.pend = 1'b0;
      end else if (trig) begin
         d.pend = 1'b1;
      end
      // tag lookup answer
      if (q.tag_req && tag_ack) begin
         d.tag     = tag_data;
         d.tag_req = 1'b0;
      end
      unique case (q.state)
         // idle: start on a trigger, drive x plate first
         S_IDLE: begin
            if ((mode != MODE_OFF) && (q.pend || trig)) begin
               d.pend      = 1'b0;
               d.state     = S_XC;
               d.sw_x      = 1'b1;
               d.mux_sel   = MUX_XPL;
               d.adc_start = 1'b1;
            end
         end
         // x done: switch to y plate
         S_XC: begin
            if (adc_done) begin
               d.x_s       = adc_data;
               d.state     = S_YC;
               d.sw_x      = 1'b0;
               d.sw_y      = 1'b1;
               d.mux_sel   = MUX_YPL;
               d.adc_start = 1'b1;
            end
         end
         // y done: switch to resistance path
         S_YC: begin
            if (adc_done) begin
               d.y_s       = adc_data;
               d.state     = S_ZC;
               d.sw_y      = 1'b0;
               d.sw_z      = 1'b1;
               d.mux_sel   = MUX_ZPL;
               d.adc_start = 1'b1;
            end
         end
         // resistance done: release panel, start transform
         S_ZC: begin
            if (adc_done) begin
               d.z_s   = adc_data;
               d.pen_s = q.pen;
               d.sw_z  = 1'b0;
               d.xf_go = 1'b1;
               d.state = S_XF;
            end
         end
         // transform done: publish raw, screen and pressure readouts
         S_XF: begin
            if (xf_done) begin
               d.state    = S_IDLE;
               d.acq_done = 1'b1;
               d.touched  = accept;
               // pressure reading, or default with no contact
               d.rz = q.pen_s ? {ZPAD, q.z_s} : RZ_NONE;
               if (accept) begin
                  d.raw_x = {ZPAD, q.x_s};
                  d.raw_y = {ZPAD, q.y_s};
                  d.scr_x = xf_sx;
                  d.scr_y = xf_sy;
                  // launch a lookup unless one is still running
                  if (!q.tag_req) begin
                     d.tag_req = 1'b1;
                     d.tag_x   = xf_sx;
                     d.tag_y   = xf_sy;
                  end
               end else begin
                  d.raw_x = RAW_NONE;
                  d.raw_y = RAW_NONE;
                  d.scr_x = SCR_NONE;
                  d.scr_y = SCR_NONE;
                  if (!q.tag_req) begin
                     d.tag = TAG_NONE;
                  end
               end
            end
         end
         default: begin
            d.state = S_IDLE;  // illegal code recovers to idle
         end
      endcase
   end

   // -------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q       <= '0;
         q.state <= S_IDLE;
         q.raw_x <= RAW_NONE;
         q.raw_y <= RAW_NONE;
         q.scr_x <= SCR_NONE;
         q.scr_y <= SCR_NONE;
         q.rz    <= RZ_NONE;
      end else begin
         q <= d;
      end
   end

   // outputs, all straight from the state register
   assign adc_start              = q.adc_start;
   assign mux_sel                = q.mux_sel;
   assign sw_x_drive             = q.sw_x;
   assign sw_y_drive             = q.sw_y;
   assign sw_z_drive             = q.sw_z;
   assign raw_coord_reg          = {q.raw_x, q.raw_y};
   assign screen_coord_reg       = {q.scr_x, q.scr_y};
   assign tag_lookup_coord_reg   = {q.tag_x, q.tag_y};
   assign contact_resistance_reg = q.rz;
   assign tag_reg                = q.tag;
   assign tag_req                = q.tag_req;
   assign touch_event            = q.pen_evt;
   assign acq_done               = q.acq_done;

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_off_idle;
      (mode == MODE_OFF) && (q.state == S_IDLE) |=> (q.state == S_IDLE);
   endproperty
   a_off_idle: assert property (p_off_idle)
      else $error("acquisition started in off mode");

   property p_oneshot;
      (q.state == S_IDLE) && (mode == MODE_ONESHOT) && mode_wr
         |=> adc_start && sw_x_drive && (q.state == S_XC);
   endproperty
   a_oneshot: assert property (p_oneshot)
      else $error("one-shot write did not start acquisition");

   property p_frame;
      (q.state == S_IDLE) && (mode == MODE_FRAME) && frame_sync
         |=> adc_start;
   endproperty
   a_frame: assert property (p_frame)
      else $error("frame sync did not start acquisition");

   property p_cnt;
      (mode == MODE_CONT) && (q.cnt == CONT_LAST) |=> (q.cnt == 16'h0000);
   endproperty
   a_cnt: assert property (p_cnt)
      else $error("continuous spacing counter did not wrap");

   property p_switch;
      adc_start |-> $onehot({sw_x_drive, sw_y_drive, sw_z_drive});
   endproperty
   a_switch: assert property (p_switch)
      else $error("conversion without exactly one plate switch");

   property p_update;
      (q.state == S_XF) && xf_done |=> acq_done ##1 !acq_done;
   endproperty
   a_update: assert property (p_update)
      else $error("readouts not updated after transform");

   property p_raw_range;
      acq_done && q.touched |-> (raw_coord_reg[31:16] <= 16'h03ff)
                             && (raw_coord_reg[15:0] <= 16'h03ff);
   endproperty
   a_raw_range: assert property (p_raw_range)
      else $error("raw coordinate out of range");

   property p_none;
      acq_done && !q.touched |-> (raw_coord_reg == {RAW_NONE, RAW_NONE})
                              && (screen_coord_reg == {SCR_NONE, SCR_NONE});
   endproperty
   a_none: assert property (p_none)
      else $error("no-touch readout values wrong");

   property p_thresh;
      acq_done && q.touched |-> contact_resistance_reg
                                < $past(pressure_threshold_reg);
   endproperty
   a_thresh: assert property (p_thresh)
      else $error("touch accepted above pressure threshold");

   property p_rz_none;
      acq_done && !q.pen_s |-> (contact_resistance_reg == RZ_NONE);
   endproperty
   a_rz_none: assert property (p_rz_none)
      else $error("pressure not at default without contact");

   property p_tag_xy;
      $rose(tag_req) |-> (tag_lookup_coord_reg == screen_coord_reg);
   endproperty
   a_tag_xy: assert property (p_tag_xy)
      else $error("tag lookup coordinate not recorded");

   property p_tag_ans;
      tag_req && tag_ack |=> !tag_req && (tag_reg == $past(tag_data));
   endproperty
   a_tag_ans: assert property (p_tag_ans)
      else $error("tag answer not stored");

   c_oneshot: cover property ((mode == MODE_ONESHOT) && acq_done);
   c_cont:    cover property ((mode == MODE_CONT) && acq_done && q.touched);
   c_tag:     cover property (tag_req && tag_ack);
endmodule

`default_nettype wire

// ==== test_resistive_touch_engine.sv ====
// self-checking testbench of the resistive touch engine
`timescale 1ns/100ps
`default_nettype none
module test_resistive_touch_engine;
   logic        clk, rst, mode_wr, frame_sync, pen_down; // drive
   logic [1:0]  mode;                  // mode field
   logic [15:0] thr;                   // pressure threshold
   logic [31:0] cf [6];                // coefficients a..f
   logic [9:0]  xv, yv, zv;            // panel levels
   logic [7:0]  tv;                    // tag under point
   logic        adc_start, adc_done, tag_req, tag_ack, touch_event, acq_done;
   logic [1:0]  mux_sel;               // converter input
   logic        sw_x, sw_y, sw_z;      // plate switches
   logic [9:0]  adc_data;              // converter result
   logic [7:0]  tag_data, tag_reg;     // tag answer and readout
   logic [31:0] raw_q, scr_q, tagxy_q; // coordinate readouts
   logic [15:0] rz_q, sx, sy;          // pressure, expected screen
   logic        acc;                   // last sample accepted
   int          bad_count, cmp_count, n, i, j;
   resistive_touch_engine #(.CONT_CYCLES(50)) i_resistive_touch_engine (
      .clk(clk), .rst(rst), .mode(mode), .mode_wr(mode_wr),
      .frame_sync(frame_sync), .pen_down(pen_down),
      .pressure_threshold_reg(thr), .coef_a(cf[0]), .coef_b(cf[1]),
      .coef_c(cf[2]), .coef_d(cf[3]), .coef_e(cf[4]), .coef_f(cf[5]),
      .adc_done(adc_done), .adc_data(adc_data), .tag_ack(tag_ack),
      .tag_data(tag_data), .adc_start(adc_start), .mux_sel(mux_sel),
      .sw_x_drive(sw_x), .sw_y_drive(sw_y), .sw_z_drive(sw_z),
      .raw_coord_reg(raw_q), .screen_coord_reg(scr_q),
      .tag_lookup_coord_reg(tagxy_q), .contact_resistance_reg(rz_q),
      .tag_reg(tag_reg), .tag_req(tag_req), .touch_event(touch_event),
      .acq_done(acq_done));
   touch_panel_model i_touch_panel_model (
      .clk(clk), .adc_start(adc_start), .mux_sel(mux_sel),
      .sw_x(sw_x), .sw_y(sw_y), .sw_z(sw_z),
      .tag_req(tag_req), .xv(xv), .yv(yv), .zv(zv), .tv(tv),
      .adc_done(adc_done), .adc_data(adc_data), .tag_ack(tag_ack),
      .tag_data(tag_data));
   // saturating 16.16 transform of one axis
   function automatic logic [15:0] xf(input logic [31:0] g1, g2, off,
                                      input logic [9:0] v1, v2);
      longint s;
      s = ($signed(g1) * longint'(v1) + $signed(g2) * longint'(v2)
           + $signed(off)) >>> 16;
      if (s > 32767) s = 32767;
      if (s < -32768) s = -32768;
      return s[15:0];
   endfunction
   task automatic cmp(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // readouts after an update
   task automatic chk;
      acc = pen_down && ({6'h00, zv} < thr);
      sx = xf(cf[0], cf[1], cf[2], xv, yv);
      sy = xf(cf[3], cf[4], cf[5], xv, yv);
      cmp("raw", acc ? {6'h00, xv, 6'h00, yv} : 32'hffffffff, raw_q);
      cmp("screen", acc ? {sx, sy} : 32'h80008000, scr_q);
      cmp("rz", pen_down ? {22'h0, zv} : 32'h7fff, {16'h0, rz_q});
   endtask
   // trigger k: bit0 write, bit1 frame sync, bit2 second write
   task automatic run(input logic [1:0] m, input logic [2:0] k,
                      input int cy);
      n = 0;
      @(negedge clk);
      mode = m;
      mode_wr = k[0];
      frame_sync = k[1];
      for (i = 0; i < cy; i++) begin
         @(negedge clk);
         mode_wr = (i == 0) & k[2];
         frame_sync = 1'b0;
         if (acq_done === 1'b1) begin
            n++;
            chk();
         end
      end
      if (acc) cmp("tagxy", {sx, sy}, tagxy_q);
      cmp("tag", acc ? {24'h0, tv} : 32'h0, {24'h0, tag_reg});
   endtask
   task automatic end_of_test;
      if (bad_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #5_000_000;
      bad_count++;
      end_of_test();
   end
   initial begin
      n = $urandom(80481);
      bad_count = 0;
      cmp_count = 0;
      {rst, mode_wr, frame_sync, pen_down, mode} = 6'h20;
      thr = 16'h0200;
      cf = '{32'h00010000, 32'h0, 32'h0, 32'h0, 32'h00010000, 32'h0};
      {xv, yv, zv, tv} = {10'h123, 10'h3ff, 10'h080, 8'h5a};
      acc = 1'b0;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      chk();
      // pen contact still reported with acquisition stopped
      pen_down = 1'b1;
      n = 0;
      repeat (4) @(negedge clk) n += (touch_event === 1'b1);
      cmp("event", 1, n);
      run(2'h0, 3'h3, 80);
      cmp("off", 0, n);
      // threshold corners: one below, equal, then no contact
      for (j = 0; j < 3; j++) begin
         zv = (j == 0) ? 10'h1ff : 10'h200;
         pen_down = (j != 2);
         run(2'h1, 3'h1, 80);
         cmp("oneshot", 1, n);
      end
      // random points, coefficients and thresholds, back-to-back writes
      for (j = 0; j < 10; j++) begin
         {xv, yv, zv, tv} = 38'({$urandom, $urandom});
         thr = 16'($urandom % 1100);
         pen_down = ($urandom % 4) != 0;
         for (i = 0; i < 6; i++)
            cf[i] = j[0] ? $urandom : $urandom % 32'h00030000;
         run(2'h1, {j[1], 2'h1}, 120);
         cmp("writes", j[1] ? 2 : 1, n);
      end
      pen_down = 1'b1;
      zv = 10'h010;
      thr = 16'h0100;
      for (j = 0; j < 3; j++) begin
         run(2'h2, 3'h2, 60);
         cmp("frame", 1, n);
      end
      run(2'h3, 3'h0, 500);
      cmp("cont", 1, (n >= 8 && n <= 11));
      run(2'h0, 3'h0, 40);
      run(2'h0, 3'h3, 150);
      cmp("stop", 0, n);
      end_of_test();
   end
endmodule
`default_nettype wire

// ==== touch_panel_model.sv ====
// behavioural panel, converter and tag buffer facing the touch engine
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// converter and tag buffer answering after a random delay
// ---------------------------------------------------------------------------
module touch_panel_model (
   input  wire logic       clk,       // system clock
   input  wire logic       adc_start, // convert request
   input  wire logic [1:0] mux_sel,   // sensed plate
   input  wire logic       sw_x,      // x plate driven
   input  wire logic       sw_y,      // y plate driven
   input  wire logic       sw_z,      // contact path driven
   input  wire logic       tag_req,   // lookup request
   input  wire logic [9:0] xv,        // x plate level
   input  wire logic [9:0] yv,        // y plate level
   input  wire logic [9:0] zv,        // contact level
   input  wire logic [7:0] tv,        // tag under the point
   output logic            adc_done,  // result pulse
   output logic      [9:0] adc_data,  // conversion result
   output logic            tag_ack,   // lookup answer
   output logic      [7:0] tag_data   // looked-up tag
);
   int         acnt;  // cycles left in conversion
   int         tcnt;  // cycles left in lookup
   logic [1:0] sel;   // input latched at start
   logic [2:0] sw;    // plate switch pattern at result time
   logic       a_rdy; // converter result this edge
   logic [9:0] av;    // converter data this edge
   logic       t_rdy; // lookup answer this edge
   logic [7:0] tvv;   // lookup data this edge
   // data lines toggle outside the valid cycle so stale reads show up
   always @(negedge clk) begin
      a_rdy = 1'b0;
      av    = ~adc_data;
      t_rdy = 1'b0;
      tvv   = ~tag_data;
      if (adc_start) begin
         acnt = 1 + $urandom % 4;
         sel = mux_sel;
      end else if (acnt > 0) begin
         acnt = acnt - 1;
         if (acnt == 0) begin
            a_rdy = 1'b1;
            av = (sel == 2'h0) ? xv : (sel == 2'h1) ? yv : zv;
            // a wrong plate switch at result time inverts the reading
            sw = {sw_x, sw_y, sw_z};
            if (sw != ((sel == 2'h0) ? 3'h4 : (sel == 2'h1) ? 3'h2 : 3'h1))
               av = ~av;
         end
      end
      if (tag_req && !tag_ack && tcnt == 0) begin
         tcnt = 1 + $urandom % 6;
      end else if (tcnt > 0) begin
         tcnt = tcnt - 1;
         if (tcnt == 0) begin
            t_rdy = 1'b1;
            tvv = tv;
         end
      end
      adc_done <= a_rdy;
      adc_data <= av;
      tag_ack  <= t_rdy;
      tag_data <= tvv;
   end
endmodule
`default_nettype wire

// ==== touch_xform.sv ====
// package of shared constants and the coordinate transform module
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------------------
// shared constants
// ---------------------------------------------------------------------------
package touch_pkg;
   // acquisition mode codes
   localparam logic [1:0] MODE_OFF     = 2'h0;  // acquisition stopped
   localparam logic [1:0] MODE_ONESHOT = 2'h1;  // one per host write
   localparam logic [1:0] MODE_FRAME   = 2'h2;  // one per frame sync
   localparam logic [1:0] MODE_CONT    = 2'h3;  // free running
   // converter, coordinate and coefficient widths
   localparam int         ADC_W        = 10;    // converter result width
   localparam int         CRD_W        = 16;    // register field width
   localparam int         COEF_W       = 32;    // transform coefficient
   localparam int         FRAC_BITS    = 16;    // coefficient fraction bits
   // no-touch readout values and adc padding
   localparam logic [15:0] RAW_NONE    = 16'hffff;  // raw field, no touch
   localparam logic [15:0] SCR_NONE    = 16'h8000;  // screen field, no touch
   localparam logic [15:0] RZ_NONE     = 16'h7fff;  // pressure, no touch
   localparam logic [7:0]  TAG_NONE    = 8'h00;     // tag with no touch
   localparam logic [5:0]  ZPAD        = 6'h00;     // widen adc to 16 bits
   // input multiplexer selects
   localparam logic [1:0] MUX_XPL      = 2'h0;  // sense for x position
   localparam logic [1:0] MUX_YPL      = 2'h1;  // sense for y position
   localparam logic [1:0] MUX_ZPL      = 2'h2;  // sense contact resistance
   // timing
   localparam int         CLK_HZ       = 10_000_000;  // system clock
   localparam int         CONT_PERIOD_US = 1000;      // continuous spacing
   localparam int         CONT_CYCLES_DEF =
      CONT_PERIOD_US * (CLK_HZ / 1_000_000);          // cycles per sample
endpackage

// ---------------------------------------------------------------------------
// transform: screen = (a*x + b*y + c) >> frac, saturated, one cycle latency
// ---------------------------------------------------------------------------
module touch_xform (
   input  wire logic                         clk,     // system clock
   input  wire logic                         rst,     // async reset, high
   input  wire logic                         go,      // start pulse
   input  wire logic [touch_pkg::ADC_W-1:0]  x,       // raw x
   input  wire logic [touch_pkg::ADC_W-1:0]  y,       // raw y
   input  wire logic [touch_pkg::COEF_W-1:0] coef_a,  // x gain for screen x
   input  wire logic [touch_pkg::COEF_W-1:0] coef_b,  // y gain for screen x
   input  wire logic [touch_pkg::COEF_W-1:0] coef_c,  // offset of screen x
   input  wire logic [touch_pkg::COEF_W-1:0] coef_d,  // x gain for screen y
   input  wire logic [touch_pkg::COEF_W-1:0] coef_e,  // y gain for screen y
   input  wire logic [touch_pkg::COEF_W-1:0] coef_f,  // offset of screen y
   output logic      [touch_pkg::CRD_W-1:0]  sx,      // screen x, registered
   output logic      [touch_pkg::CRD_W-1:0]  sy,      // screen y, registered
   output logic                              done     // result valid pulse
);
   import touch_pkg::*;

   localparam int SUM_W = COEF_W + ADC_W + 3;  // room for two products
   localparam logic signed [SUM_W-1:0] VMAX = 45'sh0000_0000_7fff;
   localparam logic signed [SUM_W-1:0] VMIN = 45'sh1fff_ffff_8000;

   typedef struct packed {
      logic [CRD_W-1:0] sx;    // screen x result
      logic [CRD_W-1:0] sy;    // screen y result
      logic             done;  // result strobe
   } xf_s;

   xf_s q, d;  // state and its next value

   // linear combination of both axes plus offset, scaled and clamped
   function automatic logic [CRD_W-1:0] axis(
      input logic [COEF_W-1:0] g1, input logic [COEF_W-1:0] g2,
      input logic [COEF_W-1:0] off, input logic [ADC_W-1:0] v1,
      input logic [ADC_W-1:0] v2);
      logic signed [SUM_W-1:0] acc;
      acc = SUM_W'($signed(g1) * $signed({1'b0, v1}))
          + SUM_W'($signed(g2) * $signed({1'b0, v2}))
          + SUM_W'($signed(off));
      acc = acc >>> FRAC_BITS;
      if (acc > VMAX) begin  // clamp high
         axis = VMAX[CRD_W-1:0];
      end else if (acc < VMIN) begin  // clamp low
         axis = VMIN[CRD_W-1:0];
      end else begin
         axis = acc[CRD_W-1:0];
      end
   endfunction

   // next result on each start pulse
   always_comb begin
      d      = q;
      d.done = go;
      if (go) begin
         d.sx = axis(coef_a, coef_b, coef_c, x, y);
         d.sy = axis(coef_d, coef_e, coef_f, x, y);
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sx   = q.sx;
   assign sy   = q.sy;
   assign done = q.done;
endmodule

`default_nettype wire
